// ---- pkg/flow_cond_pkg.sv ----
package flow_cond_pkg;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] CTRL_OFF    = 12'h000;
   localparam logic [11:0] STEP_OFF    = 12'h004;
   localparam logic [11:0] STATUS_OFF  = 12'h008;
   localparam logic [11:0] IRQ_ST_OFF  = 12'h00C;
   localparam logic [11:0] IRQ_MSK_OFF = 12'h010;
   localparam logic [11:0] RESULT_OFF  = 12'h014;
   // ---------------------------------------------------------------
   // control fields
   // ---------------------------------------------------------------
   localparam int CTRL_LEN_LSB     = 0;
   localparam int CTRL_UNLIMIT_BIT = 8;
   localparam int STEP_EARLY_BIT   = 0;
   localparam int STEP_LATE_BIT    = 1;
   // ---------------------------------------------------------------
   // reset values and limits
   // ---------------------------------------------------------------
   localparam logic [4:0]  LEN_RESET     = 5'h01;
   localparam logic [4:0]  LEN_MAX       = 5'h15;
   localparam logic [7:0]  POS_CAL       = 8'h50;
   localparam logic [7:0]  POS_MIN       = 8'h10;
   localparam logic [7:0]  POS_MAX       = 8'hF0;
   localparam logic [3:0]  GAIN_CAL      = 4'h4;
   localparam logic [3:0]  GAIN_LIMITED  = 4'h2;
   localparam logic [3:0]  GAIN_TOP      = 4'hF;
   localparam logic [15:0] AMP_LOW       = 16'h0400;
   localparam logic [15:0] AMP_HIGH      = 16'h4000;
   localparam real         RESULT_RATE_HZ = 25.0;
   // ---------------------------------------------------------------
   // quality classes and irq bits
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      Q_STRONG = 2'b00,
      Q_WEAK   = 2'b01,
      Q_POOR   = 2'b10
   } quality_t;
   localparam int IRQ_RESULT  = 0;
   localparam int IRQ_QUALITY = 1;
   localparam int IRQ_CLAMP   = 2;
endpackage

// ---- rtl/flow_cond.sv ----
// Contract
// - median of last N results, N odd 1..21
// - output is a chosen sample, never average
// - each result advances the window one
// - gain control tracks received amplitude
// - gain limited to two levels by default
// - host may lift the gain limit
// - power-up restores calibrated window position
// - signal quality reported strong, weak, poor
// - host steps window earlier or later
// - length one passes results unchanged
//
// The APB register port and the register offsets were decided locally.
module flow_cond #(
   parameter int W = 16
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic         result_valid,
   input  wire logic [W-1:0] result_data,
   input  wire logic [15:0]  rx_amplitude,
   output logic      [W-1:0] filt_data,
   output logic              filt_valid,
   output logic      [3:0]   gain_level,
   output logic      [7:0]   window_pos,
   output logic      [1:0]   quality,
   output logic              irq
);
   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   logic wr_en;
   logic rd_en;
   logic mapped;
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;
   assign mapped  = paddr == flow_cond_pkg::CTRL_OFF    ||
                    paddr == flow_cond_pkg::STEP_OFF    ||
                    paddr == flow_cond_pkg::STATUS_OFF  ||
                    paddr == flow_cond_pkg::IRQ_ST_OFF  ||
                    paddr == flow_cond_pkg::IRQ_MSK_OFF ||
                    paddr == flow_cond_pkg::RESULT_OFF;
   assign pslverr = psel && penable && !mapped;

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   logic [4:0] len_reg;
   logic       unlimit_reg;
   logic       len_change;
   logic [4:0] len_wr;
   assign len_wr = pwdata[flow_cond_pkg::CTRL_LEN_LSB +: 5];
   assign len_change = wr_en && paddr == flow_cond_pkg::CTRL_OFF &&
                       len_wr[0] && len_wr <= flow_cond_pkg::LEN_MAX &&
                       len_wr != len_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         len_reg     <= flow_cond_pkg::LEN_RESET;
         unlimit_reg <= 1'b0;
      end else if (wr_en && paddr == flow_cond_pkg::CTRL_OFF) begin
         if (len_wr[0] && len_wr <= flow_cond_pkg::LEN_MAX)
            len_reg <= len_wr;
         unlimit_reg <= pwdata[flow_cond_pkg::CTRL_UNLIMIT_BIT];
      end
   end

   // ---------------------------------------------------------------
   // median filter
   // ---------------------------------------------------------------
   logic [W-1:0] med_data;
   logic         med_valid;

   median_select #(
      .W     (W),
      .DEPTH (21)
   ) u_median (
      .pclk         (pclk),
      .presetn      (presetn),
      .clear        (len_change),
      .push         (result_valid),
      .sample       (result_data),
      .len          (len_reg),
      .median       (med_data),
      .median_valid (med_valid)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_data  <= '0;
         filt_valid <= 1'b0;
      end else if (len_reg == 5'h01) begin
         filt_valid <= result_valid;
         if (result_valid) filt_data <= result_data;
      end else begin
         filt_valid <= med_valid;
         if (med_valid) filt_data <= med_data;
      end
   end

   // ---------------------------------------------------------------
   // gain control
   // ---------------------------------------------------------------
   logic [3:0] gain_ceiling;
   assign gain_ceiling = unlimit_reg ? flow_cond_pkg::GAIN_TOP
                       : flow_cond_pkg::GAIN_CAL + flow_cond_pkg::GAIN_LIMITED;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gain_level <= flow_cond_pkg::GAIN_CAL;
      end else if (result_valid) begin
         if (rx_amplitude < flow_cond_pkg::AMP_LOW &&
             gain_level < gain_ceiling)
            gain_level <= gain_level + 4'h1;
         else if (rx_amplitude > flow_cond_pkg::AMP_HIGH &&
                  gain_level > 4'h0)
            gain_level <= gain_level - 4'h1;
         else if (gain_level > gain_ceiling)
            gain_level <= gain_ceiling;
      end
   end

   // ---------------------------------------------------------------
   // signal quality
   // ---------------------------------------------------------------
   flow_cond_pkg::quality_t q_next;
   always_comb begin
      if (rx_amplitude < flow_cond_pkg::AMP_LOW ||
          gain_level >= flow_cond_pkg::GAIN_CAL + flow_cond_pkg::GAIN_LIMITED)
         q_next = flow_cond_pkg::Q_POOR;
      else if (gain_level > flow_cond_pkg::GAIN_CAL)
         q_next = flow_cond_pkg::Q_WEAK;
      else
         q_next = flow_cond_pkg::Q_STRONG;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) quality <= flow_cond_pkg::Q_STRONG;
      else if (result_valid) quality <= q_next;
   end

   // ---------------------------------------------------------------
   // measurement window position
   // ---------------------------------------------------------------
   logic step_early;
   logic step_late;
   logic clamp_hit;
   assign step_early = wr_en && paddr == flow_cond_pkg::STEP_OFF &&
                       pwdata[flow_cond_pkg::STEP_EARLY_BIT] &&
                       !pwdata[flow_cond_pkg::STEP_LATE_BIT];
   assign step_late  = wr_en && paddr == flow_cond_pkg::STEP_OFF &&
                       pwdata[flow_cond_pkg::STEP_LATE_BIT] &&
                       !pwdata[flow_cond_pkg::STEP_EARLY_BIT];
   assign clamp_hit  =
      (step_early && window_pos <= flow_cond_pkg::POS_MIN) ||
      (step_late  && window_pos >= flow_cond_pkg::POS_MAX);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         window_pos <= flow_cond_pkg::POS_CAL;
      end else if (step_early && !clamp_hit) begin
         window_pos <= window_pos - 8'h01;
      end else if (step_late && !clamp_hit) begin
         window_pos <= window_pos + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // interrupts
   // ---------------------------------------------------------------
   logic [2:0] irq_st_reg;
   logic [2:0] irq_msk_reg;
   logic [2:0] irq_set;
   logic [2:0] irq_clr;
   logic [1:0] quality_prev;
   assign irq_set = {clamp_hit, quality != quality_prev, filt_valid};
   assign irq_clr = (wr_en && paddr == flow_cond_pkg::IRQ_ST_OFF)
                  ? pwdata[2:0] : 3'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) quality_prev <= flow_cond_pkg::Q_STRONG;
      else quality_prev <= quality;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq_st_reg <= 3'h0;
      else irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq_msk_reg <= 3'h0;
      else if (wr_en && paddr == flow_cond_pkg::IRQ_MSK_OFF)
         irq_msk_reg <= pwdata[2:0];
   end

   assign irq = |(irq_st_reg & irq_msk_reg);

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_comb begin
      prdata = 32'h0000_0000;
      if (rd_en) begin
         unique case (paddr)
            flow_cond_pkg::CTRL_OFF:
               prdata = {23'h0, unlimit_reg, 3'h0, len_reg};
            flow_cond_pkg::STATUS_OFF:
               prdata = {18'h0, quality, gain_level, window_pos};
            flow_cond_pkg::IRQ_ST_OFF:  prdata = {29'h0, irq_st_reg};
            flow_cond_pkg::IRQ_MSK_OFF: prdata = {29'h0, irq_msk_reg};
            flow_cond_pkg::RESULT_OFF:  prdata = {{(32-W){1'b0}}, filt_data};
            default:                    prdata = 32'h0000_0000;
         endcase
      end
   end
endmodule // flow_cond

// ---- rtl/median_select.sv ----
module median_select #(
   parameter int W     = 16,
   parameter int DEPTH = 21
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 clear,
   input  wire logic                 push,
   input  wire logic [W-1:0]         sample,
   input  wire logic [4:0]           len,
   output logic      [W-1:0]         median,
   output logic                      median_valid
);
   // ---------------------------------------------------------------
   // sample history
   // ---------------------------------------------------------------
   logic [W-1:0] hist_reg [DEPTH];
   logic [4:0]   fill_reg;
   logic [4:0]   idx_reg;
   logic         busy_reg;
   logic [W-1:0] cand_reg;
   logic [4:0]   less_cnt;
   logic [4:0]   eq_cnt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DEPTH; i++) hist_reg[i] <= '0;
      end else if (push) begin
         hist_reg[0] <= sample;
         for (int i = 1; i < DEPTH; i++) hist_reg[i] <= hist_reg[i-1];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fill_reg <= 5'h00;
      end else if (clear) begin
         fill_reg <= push ? 5'h01 : 5'h00;
      end else if (push && fill_reg < len) begin
         fill_reg <= fill_reg + 5'h01;
      end
   end

   // ---------------------------------------------------------------
   // rank count of candidate against filled entries
   // ---------------------------------------------------------------
   always_comb begin
      less_cnt = 5'h00;
      eq_cnt   = 5'h00;
      for (int i = 0; i < DEPTH; i++) begin
         if (5'(i) < fill_reg) begin
            if (hist_reg[i] < cand_reg) less_cnt = less_cnt + 5'h01;
            if (hist_reg[i] == cand_reg) eq_cnt = eq_cnt + 5'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // search: one candidate per cycle, picks a stored sample
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg     <= 1'b0;
         idx_reg      <= 5'h00;
         cand_reg     <= '0;
         median       <= '0;
         median_valid <= 1'b0;
      end else begin
         median_valid <= 1'b0;
         if (push) begin
            busy_reg <= 1'b1;
            idx_reg  <= 5'h00;
            cand_reg <= sample;
         end else if (busy_reg) begin
            if (less_cnt <= (fill_reg >> 1) &&
                less_cnt + eq_cnt > (fill_reg >> 1)) begin
               median       <= cand_reg;
               median_valid <= 1'b1;
               busy_reg     <= 1'b0;
            end else begin
               idx_reg  <= idx_reg + 5'h01;
               cand_reg <= hist_reg[idx_reg + 5'h01];
            end
         end
      end
   end
endmodule // median_select

// ---- test/flow_cond_asserts.sv ----
module flow_cond_asserts #(
   parameter int W = 16
) (
   input wire logic         pclk,
   input wire logic         presetn,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic         pwrite,
   input wire logic [11:0]  paddr,
   input wire logic [31:0]  pwdata,
   input wire logic         result_valid,
   input wire logic [W-1:0] result_data,
   input wire logic [15:0]  rx_amplitude,
   input wire logic [W-1:0] filt_data,
   input wire logic         filt_valid,
   input wire logic [3:0]   gain_level,
   input wire logic [7:0]   window_pos,
   input wire logic [1:0]   quality
);
   // --------------------------------
   // shadow of host settings
   // --------------------------------
   logic       wr;
   logic       stp;
   logic [4:0] len_reg;
   logic       unl_reg;
   assign wr  = psel && penable && pwrite;
   assign stp = wr && paddr == flow_cond_pkg::STEP_OFF;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         len_reg <= 5'h01;
         unl_reg <= 1'b0;
      end else if (wr && paddr == flow_cond_pkg::CTRL_OFF) begin
         unl_reg <= pwdata[8];
         if (pwdata[0] && pwdata[4:0] <= 5'h15) begin
            len_reg <= pwdata[4:0];
         end
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   pass_thru_a: assert property (len_reg == 5'h01 && result_valid
      |=> filt_valid && filt_data == $past(result_data))
      else $error("length one did not pass the result");
   pulse_one_a: assert property (filt_valid |=> !filt_valid)
      else $error("filtered valid longer than one cycle");
   gain_cap_a: assert property (!unl_reg && gain_level >
      $past(gain_level) |-> gain_level <= 4'h6)
      else $error("gain raised past limit");
   gain_cause_a: assert property ($changed(gain_level)
      |-> $past(result_valid) || $past(result_valid, 2))
      else $error("gain moved without a result");
   qual_poor_a: assert property (result_valid && rx_amplitude <
      16'h0400 |-> ##[1:2] quality == flow_cond_pkg::Q_POOR)
      else $error("weak amplitude not classed poor");
   pos_range_a: assert property (window_pos >= 8'h10
      && window_pos <= 8'hF0)
      else $error("window position out of range");
   pos_step_a: assert property ($changed(window_pos) |-> $past(stp)
      && (window_pos == $past(window_pos) + 8'h01
      || window_pos == $past(window_pos) - 8'h01))
      else $error("window moved without a single step");
   pos_reset_a: assert property (!$past(presetn)
      |-> window_pos == 8'h50)
      else $error("window not at calibration after reset");
endmodule // flow_cond_asserts

bind flow_cond flow_cond_asserts #(.W(W)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .result_valid(result_valid), .result_data(result_data),
   .rx_amplitude(rx_amplitude), .filt_data(filt_data),
   .filt_valid(filt_valid), .gain_level(gain_level),
   .window_pos(window_pos), .quality(quality));

// ---- test/flow_cond_tb.sv ----
module flow_cond_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0, presetn = 1'b0, send = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h1999A266;
   logic        pready, pslverr, err, result_valid, filt_valid, irq, x;
   logic [15:0] result_data, rx_amplitude, filt_data, d = 16'h0, a = 16'h0;
   logic [3:0]  gain_level;
   logic [7:0]  window_pos;
   logic [1:0]  quality;
   int          num_errors = 0, num_checks = 0, len = 1, unl = 0;
   int          hist[$];
   int          lens[3] = '{3, 5, 21};
   always #2 pclk = ~pclk;
   flow_cond u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .result_valid(result_valid), .result_data(result_data),
      .rx_amplitude(rx_amplitude), .filt_data(filt_data),
      .filt_valid(filt_valid), .gain_level(gain_level),
      .window_pos(window_pos), .quality(quality), .irq(irq));
   flow_front_end u_fe (.pclk(pclk), .presetn(presetn), .send(send),
      .d(d), .a(a), .result_valid(result_valid),
      .result_data(result_data), .rx_amplitude(rx_amplitude));
   // --------------------------------
   // tasks
   // --------------------------------
   task give_verdict();
      if (num_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   function logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 50) num_errors++;
      @(posedge pclk);
   endtask
   task setlen(input int n);
      apb(1'b1, flow_cond_pkg::CTRL_OFF, 32'(n) | 32'(unl << 8));
      if (n != len) hist = {};
      len = n;
   endtask
   task res(input logic [15:0] dv, input logic [15:0] av);
      int i, n;
      int t[$];
      @(posedge pclk);
      send <= 1'b1;
      d <= dv;
      a <= av;
      @(posedge pclk);
      send <= 1'b0;
      hist.push_back(dv);
      n = hist.size() < len ? hist.size() : len;
      t = hist[hist.size() - n:$];
      t.sort();
      i = 0;
      while (filt_valid !== 1'b1 && i < 40) begin
         @(posedge pclk);
         i++;
      end
      chk("filt_data", filt_data, t[n / 2]);
      repeat (30) @(posedge pclk);
   endtask
   // --------------------------------
   // main sequence
   // --------------------------------
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      give_verdict();
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, flow_cond_pkg::STATUS_OFF, 32'h0);
      chk("status", rd[13:0], {2'b00, flow_cond_pkg::GAIN_CAL,
          flow_cond_pkg::POS_CAL});
      for (int k = 0; k < 3; k++) begin
         seed = nxt(seed);
         res(seed[15:0], 16'h1000);
      end
      foreach (lens[j]) begin
         setlen(lens[j]);
         for (int k = 0; k < lens[j] + 4; k++) begin
            seed = nxt(seed);
            res(k == 4 ? 16'h0000 : seed[15:0], 16'h1000);
         end
      end
      apb(1'b1, flow_cond_pkg::CTRL_OFF, 32'h4);
      apb(1'b0, flow_cond_pkg::CTRL_OFF, 32'h0);
      chk("ctrl_len", rd[4:0], 5'h15);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped", {err, rd[30:0]}, 32'h80000000);
      repeat (10) res(16'h0100, 16'h0100);
      chk("gain_lim", gain_level,
          flow_cond_pkg::GAIN_CAL + flow_cond_pkg::GAIN_LIMITED);
      chk("poor", quality, flow_cond_pkg::Q_POOR);
      unl = 1;
      setlen(len);
      repeat (12) res(16'h0100, 16'h0100);
      chk("gain_top", gain_level, flow_cond_pkg::GAIN_TOP);
      repeat (11) res(16'h0200, 16'h8000);
      chk("weak", quality, flow_cond_pkg::Q_WEAK);
      repeat (5) res(16'h0200, 16'h8000);
      chk("gain_low", gain_level, 4'h0);
      chk("strong", quality, flow_cond_pkg::Q_STRONG);
      apb(1'b1, flow_cond_pkg::STEP_OFF, 32'h1);
      chk("early", window_pos, 8'h4F);
      apb(1'b1, flow_cond_pkg::STEP_OFF, 32'h2);
      apb(1'b1, flow_cond_pkg::STEP_OFF, 32'h3);
      chk("late", window_pos, 8'h50);
      repeat (65) apb(1'b1, flow_cond_pkg::STEP_OFF, 32'h1);
      chk("clamp", window_pos, 8'h10);
      apb(1'b0, flow_cond_pkg::IRQ_ST_OFF, 32'h0);
      chk("clamp_irq", rd[2], 1'b1);
      apb(1'b1, flow_cond_pkg::IRQ_MSK_OFF, 32'h0);
      @(posedge pclk);
      x = irq;
      apb(1'b1, flow_cond_pkg::IRQ_MSK_OFF, 32'h7);
      @(posedge pclk);
      chk("irq_masked", x, 1'b0);
      chk("irq_mask", irq, 1'b1);
      apb(1'b1, flow_cond_pkg::IRQ_ST_OFF, 32'hFFFFFFFF);
      @(posedge pclk);
      chk("irq_clear", irq, 1'b0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("pos_reset", window_pos, flow_cond_pkg::POS_CAL);
      give_verdict();
   end
endmodule // flow_cond_tb

// ---- test/flow_front_end.sv ----
module flow_front_end (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        send,
   input  wire logic [15:0] d,
   input  wire logic [15:0] a,
   output logic             result_valid,
   output logic      [15:0] result_data,
   output logic      [15:0] rx_amplitude
);
   // --------------------------------
   // one result per send pulse
   // --------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_valid <= 1'b0;
         result_data  <= 16'h0000;
         rx_amplitude <= 16'h0000;
      end else begin
         result_valid <= send;
         result_data  <= send ? d : ~result_data;
         if (send) begin
            rx_amplitude <= a;
         end
      end
   end
endmodule // flow_front_end
